/* File: common/fpe_pkg.sv */
// package for the flash program/erase control register block
package fpe_pkg;
  // register byte addresses on the bus
  localparam logic [3:0] OFS_MODE_ONE = 4'h0;
  localparam logic [3:0] OFS_MODE_TWO = 4'h4;
  localparam logic [3:0] OFS_BLK_ONE = 4'h8;
  localparam logic [3:0] OFS_BLK_TWO = 4'hc;
  localparam logic [3:0] OFS_CTRL = 4'h0;
  // reset values
  localparam logic [7:0] RST_MODE_ONE = 8'h80;
  localparam logic [7:0] RST_MODE_TWO = 8'h00;
  localparam logic [7:0] RST_BLK = 8'h00;
  // field positions
  localparam int B_HW_PERMIT = 7;
  localparam int B_SW_EN = 6;
  localparam int B_ERASE_CHECK = 3;
  localparam int B_PROG_CHECK = 2;
  localparam int B_ERASE = 1;
  localparam int B_PROG = 0;
  localparam int B_FLASH_ERR = 7;
  localparam int B_ERASE_SETUP = 1;
  localparam int B_PROG_SETUP = 0;
  localparam int B_TOP_BLOCK = 7;
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  typedef struct packed {
    logic sw_en;
    logic erase_check;
    logic prog_check;
    logic erase;
    logic prog;
  } fpe_mode_one_s;

  typedef struct packed {
    logic erase_setup;
    logic prog_setup;
  } fpe_mode_two_s;

  typedef struct packed {
    fpe_mode_one_s m1;
    fpe_mode_two_s m2;
    logic [7:0] blk;
    logic awv;
    logic [3:0] awa;
    logic wv;
    logic [7:0] wd;
    logic wstrb0;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [7:0] rdata;
    logic [1:0] rresp;
    logic awrdy;
    logic wrdy;
    logic arrdy;
    logic [3:0] act;
  } fpe_state_s;
endpackage : fpe_pkg

/* File: design/fpe_regs.sv */
// flash program/erase control registers behind an axi4-lite slave
`timescale 1ns/10ps

// Summary of operation
// - access only while flash gate bit set
// - mode reg one resets to 80 in standby
// - bit 7 read-only permit indicator
// - software enable gates setting other bits
// - bits 5,4 read zero, ignore writes
// - bit 3 enters erase-verify mode
// - bit 2 enters program-verify mode
// - erase mode needs enable and setup
// - program mode needs enable and setup
// - mode reg two clears on reset, hw standby
// - setup bits cleared in low power, disable
// - error flag read-only, holds protection
// - bit 1 erase setup state
// - bit 0 program setup state
// - block regs clear on standby, disable
// - multiple block bits clear all
// - upper block bits select large regions
// - lower block bits select 1k blocks
// - top block bit reads zero in normal mode
// - normal mode excludes topmost 8k block
module fpe_regs (
  input wire logic i_sys_clk,
  input wire logic i_nrst,
  input wire logic i_flash_reg_gate,
  input wire logic i_hw_standby,
  input wire logic i_low_power,
  input wire logic i_normal_mode,
  input wire logic i_flash_error,
  input wire logic [3:0] i_awaddr,
  input wire logic i_awvalid,
  output logic o_awready,
  input wire logic [31:0] i_wdata,
  input wire logic [3:0] i_wstrb,
  input wire logic i_wvalid,
  output logic o_wready,
  output logic o_bvalid,
  output logic [1:0] o_bresp,
  input wire logic i_bready,
  input wire logic [3:0] i_araddr,
  input wire logic i_arvalid,
  output logic o_arready,
  output logic o_rvalid,
  output logic [31:0] o_rdata,
  output logic [1:0] o_rresp,
  input wire logic i_rready,
  output logic o_erase_check,
  output logic o_prog_check,
  output logic o_erase,
  output logic o_prog,
  output logic o_erase_setup,
  output logic o_prog_setup,
  output logic [7:0] o_erase_block
);
  fpe_pkg::fpe_state_s st_reg, st_next;
  logic [1:0] sync_reg [4];
  logic gate_s, hws_s, lp_s, err_s;
  logic [7:0] m1_rd, m2_rd, blk_rd;
  logic do_wr, wr_hit, rd_hit;
  logic [7:0] wd, blk_new;
  logic [3:0] raddr;

  // gate, standby, low power and error pins are synchronised; normal mode pin is used directly
  always_ff @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      for (int k = 0; k < 4; k++) begin
        sync_reg[k] <= 2'b00;
      end
    end else begin
      sync_reg[0] <= {sync_reg[0][0], i_flash_reg_gate};
      sync_reg[1] <= {sync_reg[1][0], i_hw_standby};
      sync_reg[2] <= {sync_reg[2][0], i_low_power};
      sync_reg[3] <= {sync_reg[3][0], i_flash_error};
    end
  end
  assign gate_s = sync_reg[0][1];
  assign hws_s = sync_reg[1][1];
  assign lp_s = sync_reg[2][1];
  assign err_s = sync_reg[3][1];

  assign m1_rd = {1'b1, st_reg.m1.sw_en, 2'b00, st_reg.m1.erase_check,
                  st_reg.m1.prog_check, st_reg.m1.erase, st_reg.m1.prog};
  assign m2_rd = {err_s, 5'b00000, st_reg.m2.erase_setup, st_reg.m2.prog_setup};
  // top block reads zero in normal mode
  assign blk_rd = {st_reg.blk[7] & ~i_normal_mode, st_reg.blk[6:0]};
  assign raddr = {i_araddr[3:2], 2'b00};
  assign wr_hit = st_reg.awa[1:0] == 2'b00;
  assign rd_hit = i_araddr[1:0] == 2'b00;
  assign do_wr = st_reg.awv && st_reg.wv && !st_reg.bvalid;
  assign wd = st_reg.wd;

  always_comb begin
    st_next = st_reg;
    blk_new = st_reg.blk;
    // address and data taken in either order
    if (i_awvalid && st_reg.awrdy) begin
      st_next.awv = 1'b1;
      st_next.awa = i_awaddr;
    end
    if (i_wvalid && st_reg.wrdy) begin
      st_next.wv = 1'b1;
      st_next.wd = i_wdata[7:0];
      st_next.wstrb0 = i_wstrb[0];
    end
    if (do_wr) begin
      st_next.awv = 1'b0;
      st_next.wv = 1'b0;
      st_next.bvalid = 1'b1;
      // only the low byte lane is used
      if (!gate_s || !wr_hit) begin
        st_next.bresp = fpe_pkg::RESP_SLVERR;
      end else begin
        st_next.bresp = fpe_pkg::RESP_OKAY;
        if (st_reg.wstrb0) begin
          unique case ({st_reg.awa[3:2], 2'b00})
            fpe_pkg::OFS_MODE_ONE: begin
              st_next.m1.sw_en = wd[fpe_pkg::B_SW_EN];
              // set only while enable is one
              st_next.m1.erase_check = wd[fpe_pkg::B_ERASE_CHECK] &
                (st_reg.m1.sw_en | st_reg.m1.erase_check);
              st_next.m1.prog_check = wd[fpe_pkg::B_PROG_CHECK] &
                (st_reg.m1.sw_en | st_reg.m1.prog_check);
              st_next.m1.erase = wd[fpe_pkg::B_ERASE] & (st_reg.m1.erase |
                (st_reg.m1.sw_en & st_reg.m2.erase_setup));
              st_next.m1.prog = wd[fpe_pkg::B_PROG] & (st_reg.m1.prog |
                (st_reg.m1.sw_en & st_reg.m2.prog_setup));
            end
            fpe_pkg::OFS_MODE_TWO: begin
              st_next.m2.erase_setup = wd[fpe_pkg::B_ERASE_SETUP] &
                (st_reg.m1.sw_en | st_reg.m2.erase_setup);
              st_next.m2.prog_setup = wd[fpe_pkg::B_PROG_SETUP] &
                (st_reg.m1.sw_en | st_reg.m2.prog_setup);
            end
            fpe_pkg::OFS_BLK_ONE: begin
              // block reg one has no storage
            end
            fpe_pkg::OFS_BLK_TWO: begin
              blk_new = wd & (st_reg.blk | {8{st_reg.m1.sw_en}});
              // top block locked in normal mode
              if (i_normal_mode) begin
                blk_new[fpe_pkg::B_TOP_BLOCK] = st_reg.blk[fpe_pkg::B_TOP_BLOCK];
              end
              st_next.blk = blk_new;
            end
          endcase
        end
      end
    end
    if (st_reg.bvalid && i_bready) begin
      st_next.bvalid = 1'b0;
    end
    if (i_arvalid && st_reg.arrdy) begin
      st_next.rvalid = 1'b1;
      st_next.rresp = fpe_pkg::RESP_OKAY;
      st_next.rdata = 8'h00;
      if (!gate_s || !rd_hit) begin
        st_next.rresp = fpe_pkg::RESP_SLVERR;
      end else begin
        unique case (raddr)
          fpe_pkg::OFS_MODE_ONE: st_next.rdata = m1_rd;
          fpe_pkg::OFS_MODE_TWO: st_next.rdata = m2_rd;
          fpe_pkg::OFS_BLK_ONE: st_next.rdata = fpe_pkg::RST_BLK;
          fpe_pkg::OFS_BLK_TWO: st_next.rdata = blk_rd;
        endcase
      end
    end else if (st_reg.rvalid && i_rready) begin
      st_next.rvalid = 1'b0;
    end
    // more than one block bit clears all
    if (!$onehot0(st_next.blk)) begin
      st_next.blk = fpe_pkg::RST_BLK;
    end
    // clear on enable low or low power
    if (!st_next.m1.sw_en || lp_s) begin
      st_next.m2 = '0;
      st_next.blk = fpe_pkg::RST_BLK;
    end
    // low power returns mode reg one to reset
    if (lp_s || hws_s) begin
      st_next.m1 = '0;
    end
    // hardware standby clears mode reg two
    if (hws_s) begin
      st_next.m2 = '0;
      st_next.blk = fpe_pkg::RST_BLK;
    end
    // readies and mode outputs leave straight from flops
    st_next.awrdy = !st_next.awv;
    st_next.wrdy = !st_next.wv;
    st_next.arrdy = !st_next.rvalid;
    // modes masked while error flag set
    st_next.act = {st_next.m1.erase_check, st_next.m1.prog_check, st_next.m1.erase,
      st_next.m1.prog} & {4{~err_s}};
  end

  always_ff @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      st_reg <= '0;
      // readies idle high out of reset
      st_reg.awrdy <= 1'b1;
      st_reg.wrdy <= 1'b1;
      st_reg.arrdy <= 1'b1;
    end else begin
      st_reg <= st_next;
    end
  end

  // software order assumed, no extra check
  // error flag not cleared by software
  assign o_awready = st_reg.awrdy;
  assign o_wready = st_reg.wrdy;
  assign o_arready = st_reg.arrdy;
  assign o_bvalid = st_reg.bvalid;
  assign o_bresp = st_reg.bresp;
  assign o_rvalid = st_reg.rvalid;
  assign o_rdata = {24'h000000, st_reg.rdata};
  assign o_rresp = st_reg.rresp;
  // flash protected while error flag set
  assign o_erase_check = st_reg.act[3];
  assign o_prog_check = st_reg.act[2];
  assign o_erase = st_reg.act[1];
  assign o_prog = st_reg.act[0];
  assign o_erase_setup = st_reg.m2.erase_setup;
  assign o_prog_setup = st_reg.m2.prog_setup;
  assign o_erase_block = st_reg.blk;

  // low power resets mode reg one
  low_power_m1_a: assert property (@(posedge i_sys_clk) disable iff (!i_nrst)
    lp_s |=> st_reg.m1 == '0)
    else $error("mode reg one not cleared in low power");
  enable_gate_a: assert property (@(posedge i_sys_clk) disable iff (!i_nrst)
    !$past(st_reg.m1.sw_en) && !$past(st_reg.m1.prog_check) |-> !st_reg.m1.prog_check)
    else $error("verify bit set without enable");
  erase_setup_a: assert property (@(posedge i_sys_clk) disable iff (!i_nrst)
    $rose(st_reg.m1.erase) |-> $past(st_reg.m2.erase_setup))
    else $error("erase entered without setup");
  prog_setup_a: assert property (@(posedge i_sys_clk) disable iff (!i_nrst)
    $rose(st_reg.m1.prog) |-> $past(st_reg.m2.prog_setup) && $past(st_reg.m1.sw_en))
    else $error("program entered without setup");
  hw_standby_a: assert property (@(posedge i_sys_clk) disable iff (!i_nrst)
    hws_s |=> st_reg.m2 == '0 && st_reg.blk == '0)
    else $error("standby did not clear");
  setup_clear_a: assert property (@(posedge i_sys_clk) disable iff (!i_nrst)
    !st_reg.m1.sw_en |-> st_reg.m2 == '0 && st_reg.blk == '0)
    else $error("setup or block kept without enable");
  blk_onehot_a: assert property (@(posedge i_sys_clk) disable iff (!i_nrst)
    $onehot0(st_reg.blk))
    else $error("more than one block bit set");
  gate_err_a: assert property (@(posedge i_sys_clk) disable iff (!i_nrst)
    do_wr && !gate_s |=> o_bvalid && o_bresp == fpe_pkg::RESP_SLVERR)
    else $error("write accepted with gate closed");
  // top bit locked in normal mode
  top_lock_a: assert property (@(posedge i_sys_clk) disable iff (!i_nrst)
    i_normal_mode && !$past(st_reg.blk[7]) && $past(i_normal_mode) |-> !st_reg.blk[7])
    else $error("top block set in normal mode");
  write_resp_a: assert property (@(posedge i_sys_clk) disable iff (!i_nrst)
    do_wr |=> o_bvalid)
    else $error("no write response");
  read_resp_a: assert property (@(posedge i_sys_clk) disable iff (!i_nrst)
    i_arvalid && st_reg.arrdy |=> o_rvalid)
    else $error("no read response");
  bad_addr_a: assert property (@(posedge i_sys_clk) disable iff (!i_nrst)
    do_wr && !wr_hit |=> o_bvalid && o_bresp == fpe_pkg::RESP_SLVERR)
    else $error("misaligned write accepted");
  rd_gate_a: assert property (@(posedge i_sys_clk) disable iff (!i_nrst)
    i_arvalid && st_reg.arrdy && !gate_s |=> o_rvalid && o_rresp == fpe_pkg::RESP_SLVERR)
    else $error("read accepted with gate closed");
  // hw standby resets mode reg one
  hw_standby_m1_a: assert property (@(posedge i_sys_clk) disable iff (!i_nrst)
    hws_s |=> st_reg.m1 == '0)
    else $error("mode reg one not cleared in standby");
  permit_read_a: assert property (@(posedge i_sys_clk) disable iff (!i_nrst)
    i_arvalid && st_reg.arrdy && gate_s && rd_hit && raddr == fpe_pkg::OFS_MODE_ONE
    |=> o_rdata[fpe_pkg::B_HW_PERMIT])
    else $error("permit bit not read as one");
  reserved_read_a: assert property (@(posedge i_sys_clk) disable iff (!i_nrst)
    i_arvalid && st_reg.arrdy && gate_s && rd_hit && raddr == fpe_pkg::OFS_MODE_ONE
    |=> o_rdata[5:4] == 2'b00)
    else $error("reserved bits not read as zero");
  erase_check_a: assert property (@(posedge i_sys_clk) disable iff (!i_nrst)
    !$past(st_reg.m1.sw_en) && !$past(st_reg.m1.erase_check) |-> !st_reg.m1.erase_check)
    else $error("erase check set without enable");
  // low power clears setup and blocks
  lp_clear_a: assert property (@(posedge i_sys_clk) disable iff (!i_nrst)
    lp_s |=> st_reg.m2 == '0 && st_reg.blk == '0)
    else $error("setup or block kept in low power");
  err_protect_a: assert property (@(posedge i_sys_clk) disable iff (!i_nrst)
    err_s |=> !o_erase_check && !o_prog_check && !o_erase && !o_prog)
    else $error("mode output active under error");
  esetup_gate_a: assert property (@(posedge i_sys_clk) disable iff (!i_nrst)
    $rose(st_reg.m2.erase_setup) |-> $past(st_reg.m1.sw_en))
    else $error("erase setup entered without enable");
  psetup_gate_a: assert property (@(posedge i_sys_clk) disable iff (!i_nrst)
    $rose(st_reg.m2.prog_setup) |-> $past(st_reg.m1.sw_en))
    else $error("program setup entered without enable");
  blk_gate_a: assert property (@(posedge i_sys_clk) disable iff (!i_nrst)
    $rose(|st_reg.blk) |-> $past(st_reg.m1.sw_en))
    else $error("block selected without enable");
  // top bit reads zero in normal mode
  top_read_a: assert property (@(posedge i_sys_clk) disable iff (!i_nrst)
    i_arvalid && st_reg.arrdy && gate_s && rd_hit && i_normal_mode &&
    raddr == fpe_pkg::OFS_BLK_TWO |=> !o_rdata[fpe_pkg::B_TOP_BLOCK])
    else $error("top block bit read in normal mode");

  prog_c: cover property (@(posedge i_sys_clk) disable iff (!i_nrst) $rose(o_prog));
  erase_c: cover property (@(posedge i_sys_clk) disable iff (!i_nrst) $rose(o_erase));
  blk_c: cover property (@(posedge i_sys_clk) disable iff (!i_nrst) $rose(|st_reg.blk));
  rd_c: cover property (@(posedge i_sys_clk) disable iff (!i_nrst) o_rvalid && i_rready);
  wr_err_c: cover property (@(posedge i_sys_clk) disable iff (!i_nrst)
    o_bvalid && o_bresp == fpe_pkg::RESP_SLVERR);
endmodule : fpe_regs

/* File: verification/fpe_cpu_model.sv */
// cpu-side axi4-lite master model for the flash control registers
`timescale 1ns/10ps
module fpe_cpu_model (
  input wire logic i_sys_clk,
  output logic [3:0] o_awaddr,
  output logic o_awvalid,
  input wire logic i_awready,
  output logic [31:0] o_wdata,
  output logic [3:0] o_wstrb,
  output logic o_wvalid,
  input wire logic i_wready,
  input wire logic i_bvalid,
  input wire logic [1:0] i_bresp,
  output logic o_bready,
  output logic [3:0] o_araddr,
  output logic o_arvalid,
  input wire logic i_arready,
  input wire logic i_rvalid,
  input wire logic [31:0] i_rdata,
  input wire logic [1:0] i_rresp,
  output logic o_rready
);
  // set when an answer never came
  logic hung;
  initial begin
    hung = 1'b0;
    o_awaddr = 4'h0;
    o_awvalid = 1'b0;
    o_wdata = 32'h0;
    o_wstrb = 4'h0;
    o_wvalid = 1'b0;
    o_bready = 1'b0;
    o_araddr = 4'h0;
    o_arvalid = 1'b0;
    o_rready = 1'b0;
  end
  task automatic write(input logic [3:0] a, input logic [7:0] d, output logic [1:0] r);
    logic got;
    got = 1'b0;
    r = 2'b11;
    @(posedge i_sys_clk);
    o_awaddr <= a;
    o_awvalid <= 1'b1;
    o_wdata <= {24'h0, d};
    o_wstrb <= 4'hf;
    o_wvalid <= 1'b1;
    o_bready <= 1'b1;
    for (int n = 0; n < 40 && !got; n++) begin
      @(posedge i_sys_clk);
      if (o_awvalid && i_awready) o_awvalid <= 1'b0;
      if (o_wvalid && i_wready) o_wvalid <= 1'b0;
      if (i_bvalid) begin
        r = i_bresp;
        o_bready <= 1'b0;
        got = 1'b1;
      end
    end
    hung = hung | !got;
  endtask : write
  task automatic read(input logic [3:0] a, output logic [31:0] d, output logic [1:0] r);
    logic got;
    got = 1'b0;
    r = 2'b11;
    d = 32'h0;
    @(posedge i_sys_clk);
    o_araddr <= a;
    o_arvalid <= 1'b1;
    o_rready <= 1'b1;
    for (int n = 0; n < 40 && !got; n++) begin
      @(posedge i_sys_clk);
      if (o_arvalid && i_arready) o_arvalid <= 1'b0;
      if (i_rvalid) begin
        d = i_rdata;
        r = i_rresp;
        o_rready <= 1'b0;
        got = 1'b1;
      end
    end
    hung = hung | !got;
  endtask : read
endmodule : fpe_cpu_model

/* File: verification/flash_program_erase_control_regs_tb_top.sv */
// self-checking bench for the flash program/erase control registers
`timescale 1ns/10ps
module flash_program_erase_control_regs_tb_top;
  localparam logic [3:0] P1 = fpe_pkg::OFS_MODE_ONE;
  localparam logic [3:0] P2 = fpe_pkg::OFS_MODE_TWO;
  localparam logic [3:0] P3 = fpe_pkg::OFS_BLK_ONE;
  localparam logic [3:0] P4 = fpe_pkg::OFS_BLK_TWO;
  localparam logic [1:0] OK = fpe_pkg::RESP_OKAY;
  localparam logic [1:0] SE = fpe_pkg::RESP_SLVERR;
  logic clk, nrst, gate, hws, lp, nm, ferr, awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready, ec, pc, er, pg, es, ps;
  logic [3:0] awaddr, araddr, wstrb;
  logic [31:0] wdata, rdata;
  logic [1:0] bresp, rresp;
  logic [7:0] blk;
  int mismatches, tests_run;
  fpe_regs dut (.i_sys_clk(clk), .i_nrst(nrst), .i_flash_reg_gate(gate), .i_hw_standby(hws),
    .i_low_power(lp), .i_normal_mode(nm), .i_flash_error(ferr), .i_awaddr(awaddr),
    .i_awvalid(awvalid), .o_awready(awready), .i_wdata(wdata), .i_wstrb(wstrb),
    .i_wvalid(wvalid), .o_wready(wready), .o_bvalid(bvalid), .o_bresp(bresp),
    .i_bready(bready), .i_araddr(araddr), .i_arvalid(arvalid), .o_arready(arready),
    .o_rvalid(rvalid), .o_rdata(rdata), .o_rresp(rresp), .i_rready(rready),
    .o_erase_check(ec),
    .o_prog_check(pc), .o_erase(er), .o_prog(pg), .o_erase_setup(es), .o_prog_setup(ps),
    .o_erase_block(blk));
  fpe_cpu_model cpu (.i_sys_clk(clk), .o_awaddr(awaddr), .o_awvalid(awvalid),
    .i_awready(awready), .o_wdata(wdata), .o_wstrb(wstrb), .o_wvalid(wvalid),
    .i_wready(wready), .i_bvalid(bvalid), .i_bresp(bresp), .o_bready(bready),
    .o_araddr(araddr), .o_arvalid(arvalid), .i_arready(arready), .i_rdata(rdata),
    .i_rvalid(rvalid), .i_rresp(rresp), .o_rready(rready));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  task automatic report_and_stop();
    if (cpu.hung) mismatches++;
    $display("checks %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : report_and_stop
  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    tests_run++;
    if (s !== e) begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  task automatic wr(input logic [3:0] a, input logic [7:0] d, input logic [1:0] e);
    logic [1:0] r;
    cpu.write(a, d, r);
    if (cpu.hung) report_and_stop();
    chk("bresp", {30'h0, r}, {30'h0, e});
  endtask : wr
  task automatic rd(input logic [3:0] a, input logic [7:0] d, input logic [1:0] e);
    logic [1:0] r;
    logic [31:0] v;
    cpu.read(a, v, r);
    if (cpu.hung) report_and_stop();
    chk("rresp", {30'h0, r}, {30'h0, e});
    if (e === OK) chk("rdata", v, {24'h0, d});
  endtask : rd
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask : cyc
  initial begin
    nrst = 1'b0;
    gate = 1'b0;
    hws = 1'b0;
    lp = 1'b0;
    nm = 1'b0;
    ferr = 1'b0;
    mismatches = 0;
    tests_run = 0;
    cyc(4);
    nrst <= 1'b1;
    wr(P1, 8'h40, SE);
    rd(P1, 8'h00, SE);
    gate <= 1'b1;
    cyc(4);
    rd(P1, 8'h80, OK);
    rd(P2, 8'h00, OK);
    rd(P4, 8'h00, OK);
    $display("test reset done");
    wr(P1, 8'h3f, OK);
    rd(P1, 8'h80, OK);
    wr(P4, 8'h01, OK);
    rd(P4, 8'h00, OK);
    wr(P1, 8'h43, OK);
    rd(P1, 8'hc0, OK);
    wr(P2, 8'h03, OK);
    rd(P2, 8'h03, OK);
    wr(P1, 8'h7f, OK);
    rd(P1, 8'hcf, OK);
    chk("modes", {26'h0, ec, pc, er, pg, es, ps}, 32'h3f);
    ferr <= 1'b1;
    cyc(4);
    rd(P2, 8'h83, OK);
    chk("protect", {28'h0, ec, pc, er, pg}, 32'h0);
    ferr <= 1'b0;
    cyc(4);
    wr(P1, 8'h40, OK);
    rd(P1, 8'hc0, OK);
    $display("test modes done");
    for (int i = 0; i < 8; i++) begin
      wr(P4, 8'(8'h01 << i), OK);
      chk("block", {24'h0, blk}, {24'h0, 8'(8'h01 << i)});
    end
    wr(P4, 8'h03, OK);
    rd(P4, 8'h00, OK);
    nm <= 1'b1;
    wr(P4, 8'h80, OK);
    rd(P4, 8'h00, OK);
    nm <= 1'b0;
    rd(P4, 8'h00, OK);
    wr(P4, 8'h80, OK);
    nm <= 1'b1;
    rd(P4, 8'h00, OK);
    nm <= 1'b0;
    rd(P4, 8'h80, OK);
    wr(P3, 8'hff, OK);
    rd(P3, 8'h00, OK);
    wr(P4, 8'h04, OK);
    wr(P1, 8'h00, OK);
    rd(P2, 8'h00, OK);
    rd(P4, 8'h00, OK);
    wr(4'h2, 8'h40, SE);
    rd(4'h6, 8'h00, SE);
    $display("test blocks done");
    for (int i = 0; i < 2; i++) begin
      wr(P1, 8'h40, OK);
      wr(P2, 8'h03, OK);
      wr(P4, 8'h02, OK);
      if (i == 0) lp <= 1'b1;
      else hws <= 1'b1;
      cyc(4);
      lp <= 1'b0;
      hws <= 1'b0;
      cyc(4);
      rd(P1, 8'h80, OK);
      rd(P2, 8'h00, OK);
      rd(P4, 8'h00, OK);
    end
    $display("test standby done");
    report_and_stop();
  end
endmodule : flash_program_erase_control_regs_tb_top
